/* File: design/wsw_regs.svh */
`ifndef WSW_REGS_SVH
`define WSW_REGS_SVH
// Register byte addresses on the APB
`define WSW_WATCHDOG_SOFT_CONTROL_ADDR 8'h00
`define WSW_RESET_CAUSE_CONTROL_ADDR 8'h04
`define WSW_CFG_ADDR 8'h08
`define WSW_STAT_ADDR 8'h0c
// Field positions
`define WSW_SWEN_BIT 0
`define WSW_PD_BIT 3
`define WSW_TO_BIT 4
`define WSW_CFGEN_BIT 0
`define WSW_PS_LSB 1
`define WSW_PS_MSB 3
// Reset values
`define WSW_SWEN_RST 1'b0
`define WSW_FLAG_RST 1'b1
// Watchdog timing
`define WSW_POST_MAX 8'h80
`define WSW_BASE_TICKS 16'h0100
// Oscillator start-up: periods, period and clock in ns
`define WSW_OST_PERIODS 1024
`define WSW_OSC_PERIOD_NS 5
`define WSW_CLK_PERIOD_NS 5
`define WSW_OST_CYCLES ((`WSW_OST_PERIODS*`WSW_OSC_PERIOD_NS+`WSW_CLK_PERIOD_NS-1)/`WSW_CLK_PERIOD_NS)
// Crystal oscillator select codes
`define WSW_OSC_LP 3'h0
`define WSW_OSC_XT 3'h1
`define WSW_OSC_HS 3'h2
`define WSW_OSC_HSPLL 3'h6
// Table read address map
`define WSW_ID_FIRST 22'h200000
`define WSW_ID_LAST 22'h200004
`define WSW_CP_OFF 8'hff
// Sources able to wake without on-chip clocks
`define WSW_WAKE_MASK 16'h0fff
`define WSW_PC_STEP 21'h000002
`endif

/* File: design/wsw_pkg.sv */
package wsw_pkg;
    // Power state, one-hot
    typedef enum logic [2:0] {
        WSW_RUN = 3'b001,
        WSW_SLEEP = 3'b010,
        WSW_START = 3'b100
    } wsw_state_type;
    // Postscale select field
    typedef logic [2:0] wsw_post_sel_type;
endpackage

/* File: design/wsw_ifs.sv */
`timescale 1ns/1ps
`default_nettype none
// Control link to the watchdog counter
interface wsw_wdt_if;
    logic run; // Counter enabled
    logic clear; // Synchronous clear
    logic tick; // RC oscillator tick
    wsw_pkg::wsw_post_sel_type post_sel; // Postscale select
    logic timeout; // One-cycle time-out
    modport ctrl(output run, clear, tick, post_sel, input timeout);
    modport cnt(input run, clear, tick, post_sel, output timeout);
endinterface
// Link to the table read guard
interface wsw_tbl_if;
    logic [21:0] addr; // Table read address
    logic verify; // Programming verify access
    logic [7:0] cp; // Code protect bits
    logic allow; // Read permitted
    modport ctrl(output addr, verify, cp, input allow);
    modport grd(input addr, verify, cp, output allow);
endinterface
`default_nettype wire

/* File: design/wsw_wdt_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wsw_regs.svh"
module wsw_wdt_counter #(
    parameter logic [15:0] BASE_TICKS = `WSW_BASE_TICKS
) (
    input wire logic clk_in, // Core clock
    input wire logic rst_in, // Async reset, high
    wsw_wdt_if.cnt wdt // Control link
);
    logic [15:0] base_reg, base_next; // Base period count
    logic [7:0] post_reg, post_next; // Postscaler count
    logic tmo_reg, tmo_next; // Time-out pulse
    logic [7:0] limit; // Postscale ratio

    // Ratio halves per select step, 128 down to 1
    function automatic logic [7:0] post_limit(input wsw_pkg::wsw_post_sel_type sel);
        post_limit = `WSW_POST_MAX >> sel;
    endfunction

    assign limit = post_limit(wdt.post_sel);
    assign wdt.timeout = tmo_reg;

    // Next counts
    always_comb begin
        base_next = base_reg;
        post_next = post_reg;
        tmo_next = 1'b0;
        if (wdt.clear || !wdt.run) begin
            // Clear or disabled: both stages held at zero
            base_next = 16'h0000;
            post_next = 8'h00;
        end else if (wdt.tick) begin
            if (base_reg == BASE_TICKS - 16'h0001) begin
                base_next = 16'h0000;
                if (post_reg == limit - 8'h01) begin
                    post_next = 8'h00;
                    tmo_next = 1'b1;
                end else begin
                    post_next = post_reg + 8'h01;
                end
            end else begin
                base_next = base_reg + 16'h0001;
            end
        end
    end

    // Count registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_reg <= 16'h0000;
            post_reg <= 8'h00;
            tmo_reg <= 1'b0;
        end else begin
            base_reg <= base_next;
            post_reg <= post_next;
            tmo_reg <= tmo_next;
        end
    end
endmodule
`default_nettype wire

/* File: design/wsw_tbl_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wsw_regs.svh"
module wsw_tbl_guard (
    input wire logic clk_in, // Core clock
    input wire logic rst_in, // Async reset, high
    wsw_tbl_if.grd tbl // Guard link
);
    logic allow_reg, allow_next; // Registered verdict
    logic id_hit; // Address in ID block
    logic prog_hit; // Address in program memory

    assign id_hit = (tbl.addr >= `WSW_ID_FIRST) && (tbl.addr <= `WSW_ID_LAST);
    assign prog_hit = tbl.addr < `WSW_ID_FIRST;
    assign tbl.allow = allow_reg;

    // Verdict: ID block always open, program memory verify blocked when protected
    always_comb begin
        allow_next = 1'b1;
        if (id_hit) begin
            allow_next = 1'b1;
        end else if (prog_hit && tbl.verify && (tbl.cp != `WSW_CP_OFF)) begin
            allow_next = 1'b0;
        end
    end

    // Verdict register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            allow_reg <= 1'b0;
        end else begin
            allow_reg <= allow_next;
        end
    end
endmodule
`default_nettype wire

/* File: design/wsw_top.sv */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wsw_regs.svh"
module wsw_top #(
    parameter logic [15:0] WDT_BASE_TICKS = `WSW_BASE_TICKS
) (
    input wire logic CORE_CLK_IN, // Core clock, 200 MHz
    input wire logic RST_IN, // Power-on reset, high
    input wire logic PSEL_IN, // APB select
    input wire logic PENABLE_IN, // APB enable
    input wire logic PWRITE_IN, // APB write
    input wire logic [7:0] PADDR_IN, // APB byte address
    input wire logic [31:0] PWDATA_IN, // APB write data
    input wire logic [3:0] PSTRB_IN, // APB byte strobes
    output logic [31:0] PRDATA_OUT, // APB read data
    output logic PREADY_OUT, // APB ready
    output logic PSLVERR_OUT, // APB error
    input wire logic MASTER_CLEAR_PIN_N_IN, // External reset pin, low
    input wire logic WDT_RC_TICK_IN, // RC oscillator tick
    input wire logic [7:0] WDT_CONFIG_BYTE_IN, // Watchdog config byte
    input wire logic [2:0] OSC_SELECT_IN, // Oscillator mode config
    input wire logic [7:0] CODE_PROTECT_IN, // Code protect config
    input wire logic SLEEP_INSTR_IN, // Sleep executes, pulse
    input wire logic WDT_CLEAR_INSTR_IN, // Watchdog clear, pulse
    input wire logic PRESCALER_ON_WDT_IN, // Prescaler assigned
    input wire logic GLOBAL_IRQ_ENABLE_IN, // Global enable
    input wire logic [15:0] IRQ_FLAG_IN, // Interrupt flags
    input wire logic [15:0] IRQ_ENABLE_IN, // Source enables
    input wire logic [20:0] PC_IN, // Address of sleep
    input wire logic [21:0] TBL_ADDR_IN, // Table read address
    input wire logic TBL_VERIFY_IN, // Verify mode access
    output logic TBL_ALLOW_OUT, // Table read permitted
    output logic DEVICE_RESET_OUT, // Device reset request
    output logic WDT_RESET_OUT, // Watchdog reset, pulse
    output logic CORE_RUN_OUT, // Core may execute
    output logic OSC_DRIVER_EN_OUT, // Main oscillator driver
    output logic IO_HOLD_OUT, // Freeze port drive
    output logic WAKE_OUT, // Resume, pulse
    output logic VECTOR_AFTER_NEXT_OUT, // Branch after next, pulse
    output logic [20:0] PREFETCH_ADDR_OUT, // Prefetch address
    output logic PREFETCH_STB_OUT, // Prefetch strobe
    output logic PRESCALER_CLEAR_OUT, // Prescaler clear, pulse
    output logic WDT_RUNNING_OUT // Watchdog active
);
    // Power state
    wsw_pkg::wsw_state_type state_reg, state_next;
    logic [10:0] ost_reg, ost_next; // Start-up delay count
    logic wake_irq_reg, wake_irq_next; // Woken by irq with global
    logic to_n_reg, to_n_next; // Timeout flag, low active
    logic pd_n_reg, pd_n_next; // Powerdown flag, low active
    logic rst_reg, rst_next; // Device reset request
    logic wrst_reg, wrst_next; // Watchdog reset pulse
    logic wake_reg, wake_next; // Wake pulse
    logic vec_reg, vec_next; // Vector pulse
    // Side effects of instructions
    logic [20:0] pf_reg, pf_next; // Prefetch address
    logic pfs_reg, pfs_next; // Prefetch strobe
    logic psc_reg, psc_next; // Prescaler clear
    // Register file
    logic swen_reg, swen_next; // Software enable
    logic [31:0] rdata_reg, rdata_next; // Read data
    // Decoded conditions
    logic cfg_en; // Config forces watchdog
    logic wdt_on; // Watchdog enabled
    logic irq_pending; // Enabled, wake-capable flag
    logic sleep_go; // Sleep really executes
    logic crystal; // Crystal mode needs delay
    logic asleep; // In sleep state
    logic wdt_tmo; // Time-out from counter
    logic master_clear_pin_n; // Master clear active
    logic mapped; // Address decodes
    logic wr_acc; // Write access phase

    wsw_wdt_if wdt_link();
    wsw_tbl_if tbl_link();

    assign master_clear_pin_n = !MASTER_CLEAR_PIN_N_IN;
    assign asleep = state_reg == wsw_pkg::WSW_SLEEP;
    assign cfg_en = WDT_CONFIG_BYTE_IN[`WSW_CFGEN_BIT];
    assign wdt_on = cfg_en || swen_reg;
    // source enable gates, global does not
    assign irq_pending = |(IRQ_FLAG_IN & IRQ_ENABLE_IN & `WSW_WAKE_MASK);
    // pending interrupt turns sleep into no-op
    assign sleep_go = SLEEP_INSTR_IN && (state_reg == wsw_pkg::WSW_RUN) && !irq_pending
        && !master_clear_pin_n;
    // Crystal modes only need start-up delay
    assign crystal = (OSC_SELECT_IN == `WSW_OSC_LP) || (OSC_SELECT_IN == `WSW_OSC_XT)
        || (OSC_SELECT_IN == `WSW_OSC_HS) || (OSC_SELECT_IN == `WSW_OSC_HSPLL);
    assign wdt_tmo = wdt_link.timeout;

    // Watchdog counter hookup
    // tick from separate RC oscillator
    assign wdt_link.tick = WDT_RC_TICK_IN;
    assign wdt_link.run = wdt_on;
    // clear and sleep restart both stages
    assign wdt_link.clear = WDT_CLEAR_INSTR_IN || sleep_go || master_clear_pin_n;
    // select decoded to ratio in counter
    assign wdt_link.post_sel = WDT_CONFIG_BYTE_IN[`WSW_PS_MSB:`WSW_PS_LSB];

    wsw_wdt_counter #(
        .BASE_TICKS(WDT_BASE_TICKS)
    ) u_counter (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .wdt(wdt_link.cnt)
    );

    // Table read guard hookup
    // program memory verify blocked when protected
    assign tbl_link.addr = TBL_ADDR_IN;
    assign tbl_link.verify = TBL_VERIFY_IN;
    assign tbl_link.cp = CODE_PROTECT_IN;
    assign TBL_ALLOW_OUT = tbl_link.allow;

    wsw_tbl_guard u_guard (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .tbl(tbl_link.grd)
    );

    // Power state machine, next values
    always_comb begin
        state_next = state_reg;
        ost_next = ost_reg;
        wake_irq_next = wake_irq_reg;
        to_n_next = to_n_reg;
        pd_n_next = pd_n_reg;
        wake_next = 1'b0;
        vec_next = 1'b0;
        if (master_clear_pin_n) begin
            state_next = wsw_pkg::WSW_RUN;
            ost_next = 11'h000;
            wake_irq_next = 1'b0;
        end else begin
            case (state_reg)
                wsw_pkg::WSW_RUN: begin
                    if (sleep_go) begin
                        state_next = wsw_pkg::WSW_SLEEP;
                        pd_n_next = 1'b0;
                        to_n_next = 1'b1;
                    end
                end
                wsw_pkg::WSW_SLEEP: begin
                    // irq after sleep entry wakes at once
                    if (wdt_tmo || irq_pending) begin
                        // crystal waits, RC and EC go
                        state_next = crystal ? wsw_pkg::WSW_START : wsw_pkg::WSW_RUN;
                        ost_next = 11'h000;
                        wake_irq_next = !wdt_tmo && GLOBAL_IRQ_ENABLE_IN;
                        wake_next = !crystal;
                        vec_next = !crystal && !wdt_tmo && GLOBAL_IRQ_ENABLE_IN;
                    end
                end
                wsw_pkg::WSW_START: begin
                    if (ost_reg == 11'(`WSW_OST_CYCLES - 1)) begin
                        state_next = wsw_pkg::WSW_RUN;
                        wake_next = 1'b1;
                        vec_next = wake_irq_reg;
                    end else begin
                        ost_next = ost_reg + 11'h001;
                    end
                end
                default: begin
                    // Illegal code recovers to run
                    state_next = wsw_pkg::WSW_RUN;
                end
            endcase
        end
        if (wdt_tmo) begin
            to_n_next = 1'b0;
        end
    end

    // Power state registers; flags set by power-on, TO flag also set on sleep entry
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= wsw_pkg::WSW_RUN;
            ost_reg <= 11'h000;
            wake_irq_reg <= 1'b0;
            to_n_reg <= `WSW_FLAG_RST;
            pd_n_reg <= `WSW_FLAG_RST;
            wake_reg <= 1'b0;
            vec_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ost_reg <= ost_next;
            wake_irq_reg <= wake_irq_next;
            to_n_reg <= to_n_next;
            pd_n_reg <= pd_n_next;
            wake_reg <= wake_next;
            vec_reg <= vec_next;
        end
    end

    // Reset requests, next values
    always_comb begin
        // awake time-out is a watchdog reset
        wrst_next = wdt_tmo && !asleep && !master_clear_pin_n;
        // pin or watchdog reset the device
        rst_next = master_clear_pin_n || wrst_next;
    end

    // Reset request registers
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rst_reg <= 1'b1;
            wrst_reg <= 1'b0;
        end else begin
            rst_reg <= rst_next;
            wrst_reg <= wrst_next;
        end
    end

    // Instruction side effects, next values
    always_comb begin
        pf_next = pf_reg;
        pfs_next = SLEEP_INSTR_IN && (state_reg == wsw_pkg::WSW_RUN);
        if (pfs_next) begin
            pf_next = PC_IN + `WSW_PC_STEP;
        end
        psc_next = WDT_CLEAR_INSTR_IN && PRESCALER_ON_WDT_IN;
    end

    // Side effect registers
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pf_reg <= 21'h000000;
            pfs_reg <= 1'b0;
            psc_reg <= 1'b0;
        end else begin
            pf_reg <= pf_next;
            pfs_reg <= pfs_next;
            psc_reg <= psc_next;
        end
    end

    // APB decode; zero wait states, so ready is constant
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    always_comb begin
        mapped = 1'b1;
        if (PADDR_IN == `WSW_WATCHDOG_SOFT_CONTROL_ADDR) begin
            mapped = 1'b1;
        end else if (PADDR_IN == `WSW_RESET_CAUSE_CONTROL_ADDR) begin
            mapped = 1'b1;
        end else if (PADDR_IN == `WSW_CFG_ADDR) begin
            mapped = 1'b1;
        end else if (PADDR_IN == `WSW_STAT_ADDR) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Register file, next values
    always_comb begin
        swen_next = swen_reg;
        rdata_next = rdata_reg;
        if (wr_acc && (PADDR_IN == `WSW_WATCHDOG_SOFT_CONTROL_ADDR) && PSTRB_IN[0]) begin
            swen_next = PWDATA_IN[`WSW_SWEN_BIT];
        end
        // Read data loaded in setup, stable in access
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            rdata_next = 32'h00000000;
            if (PADDR_IN == `WSW_WATCHDOG_SOFT_CONTROL_ADDR) begin
                rdata_next[`WSW_SWEN_BIT] = swen_reg;
            end else if (PADDR_IN == `WSW_RESET_CAUSE_CONTROL_ADDR) begin
                rdata_next[`WSW_TO_BIT] = to_n_reg;
                rdata_next[`WSW_PD_BIT] = pd_n_reg;
            end else if (PADDR_IN == `WSW_CFG_ADDR) begin
                rdata_next[7:0] = WDT_CONFIG_BYTE_IN;
            end else if (PADDR_IN == `WSW_STAT_ADDR) begin
                rdata_next[2:0] = state_reg;
                rdata_next[3] = wdt_on;
            end
        end
    end

    // Register file registers
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            swen_reg <= `WSW_SWEN_RST;
            rdata_reg <= 32'h00000000;
        end else begin
            swen_reg <= swen_next;
            rdata_reg <= rdata_next;
        end
    end

    // Bus answers
    assign PRDATA_OUT = rdata_reg;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

    // Power and reset outputs from flip-flops, oscillator driver enable through an inverter; watchdog active decoded from config input and enable
    assign DEVICE_RESET_OUT = rst_reg;
    assign WDT_RESET_OUT = wrst_reg;
    assign CORE_RUN_OUT = state_reg[0];
    assign OSC_DRIVER_EN_OUT = !state_reg[1];
    assign IO_HOLD_OUT = state_reg[1];
    assign WAKE_OUT = wake_reg;
    assign VECTOR_AFTER_NEXT_OUT = vec_reg;
    assign PREFETCH_ADDR_OUT = pf_reg;
    assign PREFETCH_STB_OUT = pfs_reg;
    assign PRESCALER_CLEAR_OUT = psc_reg;
    assign WDT_RUNNING_OUT = wdt_on;
endmodule
`default_nettype wire

/* File: verif/wsw_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module wsw_top_props (
    input wire logic CORE_CLK_IN, // Clock
    input wire logic RST_IN, // Reset
    input wire logic [7:0] WDT_CONFIG_BYTE_IN, // Config byte
    input wire logic WDT_RUNNING_OUT, // Watchdog active
    input wire logic SLEEP_INSTR_IN, // Sleep pulse
    input wire logic MASTER_CLEAR_PIN_N_IN, // Reset pin
    input wire logic [15:0] IRQ_FLAG_IN, // Flags
    input wire logic [15:0] IRQ_ENABLE_IN, // Enables
    input wire logic [20:0] PC_IN, // Sleep address
    input wire logic CORE_RUN_OUT, // Running
    input wire logic IO_HOLD_OUT, // Pin hold
    input wire logic OSC_DRIVER_EN_OUT, // Oscillator on
    input wire logic PREFETCH_STB_OUT, // Prefetch strobe
    input wire logic [20:0] PREFETCH_ADDR_OUT, // Prefetch address
    input wire logic WDT_RESET_OUT, // Watchdog reset
    input wire logic DEVICE_RESET_OUT, // Device reset
    input wire logic WAKE_OUT, // Wake pulse
    input wire logic VECTOR_AFTER_NEXT_OUT // Vector pulse
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic pend; // Wake-capable irq pending
    assign pend = |(IRQ_FLAG_IN[11:0] & IRQ_ENABLE_IN[11:0]);
    // Sleep issued while running and out of reset
    sequence s_go;
        SLEEP_INSTR_IN && CORE_RUN_OUT && MASTER_CLEAR_PIN_N_IN && !DEVICE_RESET_OUT;
    endsequence
    // Outputs of the sleeping device
    sequence s_asleep;
        !CORE_RUN_OUT && IO_HOLD_OUT && !OSC_DRIVER_EN_OUT;
    endsequence
    a_cfg_forces_on: assert property (WDT_CONFIG_BYTE_IN[0] |-> WDT_RUNNING_OUT)
        else $error("config enable did not force watchdog on");
    a_sleep_entry: assert property (s_go ##0 !pend |=> s_asleep)
        else $error("sleep entry outputs wrong");
    a_sleep_noop: assert property (s_go ##0 pend |=> CORE_RUN_OUT)
        else $error("sleep with pending irq did not act as no-op");
    a_prefetch_next: assert property (s_go |=> PREFETCH_STB_OUT
        && PREFETCH_ADDR_OUT == $past(PC_IN) + 21'h000002)
        else $error("prefetch address wrong");
    a_wdt_reset_pair: assert property (WDT_RESET_OUT |-> DEVICE_RESET_OUT ##1 !WDT_RESET_OUT)
        else $error("watchdog reset not a one-cycle device reset");
    a_wake_runs: assert property (WAKE_OUT |-> CORE_RUN_OUT ##1 !WAKE_OUT)
        else $error("wake pulse without run");
    a_wake_from_sleep: assert property ($rose(WAKE_OUT) |-> !$past(CORE_RUN_OUT))
        else $error("wake while already running");
    a_vector_wake: assert property (VECTOR_AFTER_NEXT_OUT |-> WAKE_OUT)
        else $error("vector pulse without wake");
endmodule
bind wsw_top wsw_top_props u_props (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .WDT_CONFIG_BYTE_IN(WDT_CONFIG_BYTE_IN),
    .WDT_RUNNING_OUT(WDT_RUNNING_OUT), .SLEEP_INSTR_IN(SLEEP_INSTR_IN),
    .MASTER_CLEAR_PIN_N_IN(MASTER_CLEAR_PIN_N_IN), .IRQ_FLAG_IN(IRQ_FLAG_IN),
    .IRQ_ENABLE_IN(IRQ_ENABLE_IN), .PC_IN(PC_IN), .CORE_RUN_OUT(CORE_RUN_OUT),
    .IO_HOLD_OUT(IO_HOLD_OUT), .OSC_DRIVER_EN_OUT(OSC_DRIVER_EN_OUT),
    .PREFETCH_STB_OUT(PREFETCH_STB_OUT), .PREFETCH_ADDR_OUT(PREFETCH_ADDR_OUT),
    .WDT_RESET_OUT(WDT_RESET_OUT), .DEVICE_RESET_OUT(DEVICE_RESET_OUT),
    .WAKE_OUT(WAKE_OUT), .VECTOR_AFTER_NEXT_OUT(VECTOR_AFTER_NEXT_OUT)
);
`default_nettype wire

/* File: verif/wsw_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wsw_core_model (
    input wire logic clk_in, // Core clock
    input wire logic rst_in, // Reset, high
    input wire logic sleep_req_in, // Bench asks sleep
    input wire logic clear_req_in, // Bench asks clear
    input wire logic tick_en_in, // RC oscillator on
    output logic sleep_out, // Sleep pulse
    output logic clear_out, // Clear pulse
    output logic tick_out // RC tick pulse
);
    logic [2:0] out_reg, out_next; // Registered pulses
    // Tick every other cycle, so pulses never merge
    always_comb begin
        out_next = {sleep_req_in, clear_req_in, tick_en_in && !out_reg[0]};
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_reg <= 3'h0;
        end else begin
            out_reg <= out_next;
        end
    end
    assign {sleep_out, clear_out, tick_out} = out_reg;
endmodule
`default_nettype wire

/* File: verif/watchdog_sleep_wake_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_sleep_wake_tb;
    logic clk = 1'b0, rst = 1'b1; // Clock, reset
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, err; // APB control
    logic [7:0] padr = 8'h00, cfg = 8'h0e, cp = 8'h00; // Address, config
    logic [2:0] osel = 3'h3; // Oscillator mode, RC first
    logic [31:0] pwd = 32'h0, prd, rd; // APB data
    logic pin_n = 1'b1, sreq = 1'b0, creq = 1'b0, tk = 1'b0; // Core requests
    logic psc = 1'b0, global_irq_enable = 1'b0, tver = 1'b1, slp, clr, tick; // Levels, pulses
    logic [15:0] flg = 16'h0, ien = 16'h0; // Interrupts
    logic [21:0] tadr = 22'h000100; // Table address
    logic [20:0] pfa; // Prefetch address
    logic allow, dres, wres, run, osc, hold, wake, vec, pstb, pclr, wrun; // Outputs
    logic [3:0] ev; // Awaited events
    int comparisons = 0, mismatches = 0, wn; // Counters, wait count
    assign ev = {pclr, vec, wake, wres};
    always #2.5 clk = ~clk;
    // Short base period keeps runs brief
    wsw_top #(.WDT_BASE_TICKS(16'h0008)) dut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(padr), .PWDATA_IN(pwd), .PSTRB_IN(4'hf), .PRDATA_OUT(prd),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .MASTER_CLEAR_PIN_N_IN(pin_n),
        .WDT_RC_TICK_IN(tick), .WDT_CONFIG_BYTE_IN(cfg), .OSC_SELECT_IN(osel),
        .CODE_PROTECT_IN(cp), .SLEEP_INSTR_IN(slp), .WDT_CLEAR_INSTR_IN(clr),
        .PRESCALER_ON_WDT_IN(psc), .GLOBAL_IRQ_ENABLE_IN(global_irq_enable), .IRQ_FLAG_IN(flg),
        .IRQ_ENABLE_IN(ien), .PC_IN(21'h000100), .TBL_ADDR_IN(tadr), .TBL_VERIFY_IN(tver),
        .TBL_ALLOW_OUT(allow), .DEVICE_RESET_OUT(dres), .WDT_RESET_OUT(wres),
        .CORE_RUN_OUT(run), .OSC_DRIVER_EN_OUT(osc), .IO_HOLD_OUT(hold), .WAKE_OUT(wake),
        .VECTOR_AFTER_NEXT_OUT(vec), .PREFETCH_ADDR_OUT(pfa), .PREFETCH_STB_OUT(pstb),
        .PRESCALER_CLEAR_OUT(pclr), .WDT_RUNNING_OUT(wrun)
    );
    wsw_core_model core (
        .clk_in(clk), .rst_in(rst), .sleep_req_in(sreq), .clear_req_in(creq),
        .tick_en_in(tk), .sleep_out(slp), .clear_out(clr), .tick_out(tick)
    );
    // Verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Bounded wait for one event bit
    task automatic wait_ev(input int i);
        int n;
        for (n = 0; n < 400 && ev[i] !== 1'b1; n++) @(posedge clk);
        if (n == 400) begin
            mismatches++;
            $display("unexpected at %0t: event %0d never came", $time, i);
            conclude();
        end
    endtask
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 50 && prdy !== 1'b1; n++) @(posedge clk);
        if (n == 50) begin
            mismatches++;
            $display("unexpected at %0t: ready never came", $time);
            conclude();
        end
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Core instruction request, one cycle
    task automatic instr(input logic s);
        if (s) sreq <= 1'b1;
        else creq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        creq <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0, "control reset");
        chk(wrun, 1'b0, "software off");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h18, 32'h18, "flags reset");
        apb(1'b1, 8'h00, 32'hffffffff);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1, "control readback");
        chk(wrun, 1'b1, "software enable");
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1, "unmapped read");
        flg <= 16'h0001;
        ien <= 16'h0001;
        instr(1'b1);
        chk(run, 1'b1, "pending sleep ran");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h18, 32'h18, "pending sleep flags");
        flg <= 16'h0;
        chk(allow, 1'b0, "protected verify");
        tadr <= 22'h200004;
        repeat (2) @(posedge clk);
        chk(allow, 1'b1, "id read");
        tadr <= 22'h000100;
        cp <= 8'hff;
        repeat (2) @(posedge clk);
        chk(allow, 1'b1, "unprotected verify");
        tk <= 1'b1;
        repeat (8) instr(1'b0);
        chk(dres, 1'b0, "clear held off");
        wait_ev(0);
        chk(dres, 1'b1, "timeout reset");
        tk <= 1'b0;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h10, 32'h0, "timeout flag");
        apb(1'b1, 8'h00, 32'h1);
        instr(1'b1);
        chk({run, hold, osc}, 3'b010, "asleep outputs");
        chk(pfa, 21'h000102, "prefetch");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h18, 32'h10, "sleep flags");
        tk <= 1'b1;
        wait_ev(1);
        chk(dres, 1'b0, "wake not reset");
        tk <= 1'b0;
        global_irq_enable <= 1'b1;
        ien <= 16'h1000;
        instr(1'b1);
        flg <= 16'h1001;
        repeat (8) @(posedge clk);
        chk(run, 1'b0, "masked sources woke");
        ien <= 16'h1002;
        flg <= 16'h1003;
        wait_ev(1);
        chk(vec, 1'b1, "vector after wake");
        flg <= 16'h0;
        instr(1'b1);
        pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({dres, run}, 2'b11, "master clear");
        pin_n <= 1'b1;
        cfg <= 8'h0f;
        apb(1'b1, 8'h00, 32'h0);
        chk(wrun, 1'b1, "config forces on");
        psc <= 1'b1;
        creq <= 1'b1;
        @(posedge clk);
        creq <= 1'b0;
        wait_ev(3);
        // Crystal wake: 1024 start-up cycles, wake edge, then one sampling edge
        osel <= 3'h1;
        instr(1'b1);
        flg <= 16'h0002;
        for (wn = 0; wn < 1100 && wake !== 1'b1; wn++) @(posedge clk);
        chk(wn, 32'h00000402, "crystal start-up wait");
        conclude();
    end
endmodule
`default_nettype wire
